/* File: logic/csd_map.vh */
`ifndef CSD_MAP_VH
`define CSD_MAP_VH
// Register byte addresses
`define CSD_ADDR_CTRL 12'h000
`define CSD_ADDR_LEN 12'h004
`define CSD_ADDR_DATH 12'h008
`define CSD_ADDR_DATL 12'h00c
`define CSD_ADDR_SCTL 12'h010
`define CSD_ADDR_SADR 12'h014
`define CSD_ADDR_SHIFT 12'h018
`define CSD_ADDR_ACC 12'h01c
// crc_control_main fields
`define CSD_EN_BIT 7
`define CSD_GO_BIT 6
`define CSD_BUSY_BIT 5
`define CSD_AUG_BIT 4
`define CSD_DIR_BIT 1
`define CSD_FULL_BIT 0
// crc_length_config fields
`define CSD_DATA_WORD_LENGTH_HI 7
`define CSD_DATA_WORD_LENGTH_LO 4
`define CSD_POLY_WIDTH_HI 3
`define CSD_POLY_WIDTH_LO 0
// scan_control fields
`define CSD_SEN_BIT 7
`define CSD_SGO_BIT 6
`define CSD_SBUSY_BIT 5
`define CSD_MODE_HI 1
`define CSD_MODE_LO 0
// Scan modes
`define CSD_MODE_CONC 2'b00
`define CSD_MODE_BURST 2'b01
`define CSD_MODE_PEEK 2'b10
`define CSD_MODE_TRIG 2'b11
// Reset values
`define CSD_RST_BYTE 8'h00
`define CSD_RST_WORD 16'h0000
`endif

/* File: logic/csd_crc_scan.v */
// Summary of operation
// [RULE1] Scanner activity freezes on debug halt until user execution resumes.
// [RULE2] Scan control and current address stay readable while halted.
// [RULE3] Peek missed at debug entry is performed when the instruction executes.
// [RULE4] Halt during scan may let instruction run; halt before defers both.
// [RULE5] On PC breakpoint the pending scan completes before debug entry.
// [RULE6] On data breakpoint a scan requested that cycle waits for exit.
// [RULE7] Single step: ready scan reads flash before debug is re-entered.
// [RULE8] Scan stalling a software breakpoint completes, then debug entry.
// [RULE9] Burst: halt during the go-setting instruction delays burst until exit.
// [RULE10] Burst: other halts let the current memory access finish first.
// [RULE11] Burst: halt while running suspends burst, resuming at exit.
// [RULE12] Burst: PC breakpoint or step on go instruction enters debug first.
// [RULE13] Burst: software breakpoint on go instruction; burst runs after exit.
// [RULE14] CRC enable releases CRC from reset; cleared holds it idle.
// [RULE15] crc_shift_start starts the serial shifter; clearing stops it.
// [RULE16] Busy reads one while shifting is in progress or pending.
// [RULE17] zero_augment_select appends zeros to the data stream.
// [RULE18] shift_direction one shifts LSb first, zero MSb first; bits 3:2 zero.
// [RULE19] Full reads one while input registers hold unshifted data.
// [RULE20] Upper nibble of length register is data word length minus one.
// [RULE21] Lower nibble of length register is polynomial length minus one.
// [RULE22] Writing the low data byte loads the word and sets full.
// [RULE23] Frozen scanner keeps address, mode and pending access unchanged; the code lets an access under way complete and advance the address.
// [RULE24] Scan mode encodes concurrent 00, burst 01, peek 10, triggered 11.
// [RULE25] After scan_go_a the scanner waits for CRC ready before loading.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "csd_map.vh"
module csd_crc_scan #(
    parameter AW = 16,
    parameter DW = 16
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire pslverr_o,
    output reg [31:0] prdata_o,
    // Debug controller, same clock
    input wire dbg_halted_i,
    input wire dbg_ext_halt_i,
    input wire dbg_pc_bp_i,
    input wire dbg_data_bp_i,
    input wire dbg_step_i,
    input wire dbg_sw_bp_i,
    output wire dbg_entry_ok_o,
    // Processor core, same clock
    input wire cpu_go_instr_i,
    input wire cpu_dead_cycle_i,
    input wire cpu_instr_exec_i,
    output wire cpu_stall_o,
    // Trigger and program flash
    input wire scan_trig_i,
    output reg flash_rd_o,
    output reg [AW-1:0] flash_addr_o,
    input wire [DW-1:0] flash_data_i,
    input wire flash_ack_i,
    input wire [AW-1:0] scan_end_addr_i
);
    reg rst_s1_ff, rst_ff;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_ff <= 1'b0;
            rst_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_ff <= rst_s1_ff;
        end
    end
    reg trig_s1_ff, trig_s2_ff, trig_d_ff;
    always @(posedge clock_i or negedge rst_ff) begin
        if (!rst_ff) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_d_ff <= 1'b0;
        end else begin
            trig_s1_ff <= scan_trig_i;
            trig_s2_ff <= trig_s1_ff;
            trig_d_ff <= trig_s2_ff;
        end
    end
    wire trig_rise = trig_s2_ff & ~trig_d_ff;

    // Registers
    reg crc_en_ff, crc_go_ff, aug_ff, dir_ff, full_ff;
    reg [7:0] len_ff, dath_ff, datl_ff;
    reg [DW-1:0] shift_ff, acc_ff;
    reg [4:0] cnt_ff;
    reg shifting_ff;
    reg scan_en_ff, scan_go_ff;
    reg [1:0] mode_ff;
    reg [AW-1:0] sadr_ff;
    reg pend_ff, peek_owed_ff, burst_hold_ff;

    wire wr = psel_i & penable_i & pwrite_i;
    wire known = (paddr_i == `CSD_ADDR_CTRL) | (paddr_i == `CSD_ADDR_LEN) |
        (paddr_i == `CSD_ADDR_DATH) | (paddr_i == `CSD_ADDR_DATL) |
        (paddr_i == `CSD_ADDR_SCTL) | (paddr_i == `CSD_ADDR_SADR) |
        (paddr_i == `CSD_ADDR_SHIFT) | (paddr_i == `CSD_ADDR_ACC);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~known;
    wire wr_ctrl = wr & (paddr_i == `CSD_ADDR_CTRL);
    wire wr_datl = wr & (paddr_i == `CSD_ADDR_DATL);
    wire wr_sctl = wr & (paddr_i == `CSD_ADDR_SCTL);

    wire [3:0] data_word_length = len_ff[`CSD_DATA_WORD_LENGTH_HI:`CSD_DATA_WORD_LENGTH_LO]; // RULE20
    wire [3:0] poly_width = len_ff[`CSD_POLY_WIDTH_HI:`CSD_POLY_WIDTH_LO]; // RULE21
    wire crc_busy = full_ff | shifting_ff; // RULE16
    wire crc_ready = crc_en_ff & crc_go_ff & ~full_ff; // RULE25

    // One CRC step: feedback bit, polynomial masked to active width
    function [DW-1:0] crc_step;
        input [DW-1:0] acc;
        input din;
        input [3:0] pl;
        reg [DW-1:0] mask;
        reg fb;
        begin
            mask = (16'hffff >> (4'hf - pl));
            fb = acc[pl] ^ din;
            crc_step = ((acc << 1) ^ (fb ? 16'h1021 : 16'h0000)) & mask;
        end
    endfunction

    // Scanner control
    wire halted = dbg_halted_i; // RULE1
    wire burst = (mode_ff == `CSD_MODE_BURST); // RULE24
    wire peek = (mode_ff == `CSD_MODE_PEEK);
    wire trig = (mode_ff == `CSD_MODE_TRIG);
    // A halt on the go instruction holds the burst start until exit
    wire go_halt = cpu_go_instr_i & (dbg_ext_halt_i | dbg_pc_bp_i | dbg_step_i |
        dbg_sw_bp_i); // RULE9 RULE12 RULE13
    reg acc_busy_ff;
    reg trig_seen_ff;
    wire slot = peek ? (cpu_dead_cycle_i | (peek_owed_ff & cpu_instr_exec_i))
        : trig ? trig_seen_ff : 1'b1;
    // Data breakpoint cycle postpones a new scan request
    wire block_new = dbg_data_bp_i | burst_hold_ff; // RULE6
    wire start = scan_en_ff & scan_go_ff & ~halted & ~acc_busy_ff & crc_ready &
        slot & ~block_new & ~pend_ff; // RULE25 RULE1
    // Debug entry waits for an access already under way
    assign dbg_entry_ok_o = ~acc_busy_ff; // RULE5 RULE7 RULE8 RULE10
    assign cpu_stall_o = acc_busy_ff | (burst & scan_go_ff & scan_en_ff & ~halted); // RULE4 RULE11

    always @(posedge clock_i or negedge rst_ff) begin
        if (!rst_ff) begin
            crc_en_ff <= 1'b0;
            crc_go_ff <= 1'b0;
            aug_ff <= 1'b0;
            dir_ff <= 1'b0;
            full_ff <= 1'b0;
            len_ff <= `CSD_RST_BYTE;
            dath_ff <= `CSD_RST_BYTE;
            datl_ff <= `CSD_RST_BYTE;
            shift_ff <= `CSD_RST_WORD;
            acc_ff <= `CSD_RST_WORD;
            cnt_ff <= 5'h00;
            shifting_ff <= 1'b0;
            scan_en_ff <= 1'b0;
            scan_go_ff <= 1'b0;
            mode_ff <= 2'b00;
            sadr_ff <= {AW{1'b0}};
            pend_ff <= 1'b0;
            peek_owed_ff <= 1'b0;
            burst_hold_ff <= 1'b0;
            acc_busy_ff <= 1'b0;
            trig_seen_ff <= 1'b0;
            flash_rd_o <= 1'b0;
            flash_addr_o <= {AW{1'b0}};
        end else begin
            if (wr_ctrl) begin
                crc_en_ff <= pwdata_i[`CSD_EN_BIT]; // RULE14
                crc_go_ff <= pwdata_i[`CSD_GO_BIT]; // RULE15
                aug_ff <= pwdata_i[`CSD_AUG_BIT]; // RULE17
                dir_ff <= pwdata_i[`CSD_DIR_BIT]; // RULE18
            end
            if (wr & (paddr_i == `CSD_ADDR_LEN))
                len_ff <= pwdata_i[7:0];
            if (wr & (paddr_i == `CSD_ADDR_DATH))
                dath_ff <= pwdata_i[7:0];
            if (wr & (paddr_i == `CSD_ADDR_ACC))
                acc_ff <= pwdata_i[DW-1:0];
            if (wr_sctl) begin
                scan_en_ff <= pwdata_i[`CSD_SEN_BIT];
                scan_go_ff <= pwdata_i[`CSD_SGO_BIT];
                mode_ff <= pwdata_i[`CSD_MODE_HI:`CSD_MODE_LO]; // RULE24
            end
            if (wr & (paddr_i == `CSD_ADDR_SADR) & ~scan_go_ff)
                sadr_ff <= pwdata_i[AW-1:0];
            // Shifter engine
            if (!crc_en_ff) begin
                full_ff <= 1'b0; // RULE14
                shifting_ff <= 1'b0;
                cnt_ff <= 5'h00;
            end else begin
                if (crc_go_ff & full_ff & ~shifting_ff) begin
                    shift_ff <= {dath_ff, datl_ff};
                    full_ff <= 1'b0; // RULE19
                    shifting_ff <= 1'b1;
                    cnt_ff <= {1'b0, data_word_length} + (aug_ff ? {1'b0, poly_width} + 5'h01 : 5'h00)
                        + 5'h01; // RULE17
                end else if (crc_go_ff & shifting_ff) begin // RULE15
                    if (dir_ff) begin // RULE18
                        acc_ff <= crc_step(acc_ff, shift_ff[0], poly_width);
                        shift_ff <= shift_ff >> 1;
                    end else begin
                        acc_ff <= crc_step(acc_ff, shift_ff[data_word_length], poly_width);
                        shift_ff <= shift_ff << 1;
                    end
                    cnt_ff <= cnt_ff - 5'h01;
                    if (cnt_ff == 5'h01)
                        shifting_ff <= 1'b0;
                end
                if (wr_datl | (flash_ack_i & acc_busy_ff))
                    full_ff <= 1'b1; // RULE22
            end
            if (wr_datl)
                datl_ff <= pwdata_i[7:0]; // RULE22
            // Scanner; new starts hold while halted, but an access under way still completes and advances the address
            if (!scan_en_ff) begin
                acc_busy_ff <= 1'b0;
                pend_ff <= 1'b0;
                flash_rd_o <= 1'b0;
            end else if (!halted) begin // RULE23
                burst_hold_ff <= burst & go_halt;
                if (trig & trig_rise)
                    trig_seen_ff <= 1'b1;
                if (peek & cpu_dead_cycle_i & dbg_ext_halt_i)
                    peek_owed_ff <= 1'b1; // RULE3
                if (dbg_data_bp_i & scan_go_ff)
                    pend_ff <= 1'b1; // RULE6
                if (start) begin
                    acc_busy_ff <= 1'b1;
                    flash_rd_o <= 1'b1;
                    flash_addr_o <= sadr_ff;
                    // A trigger edge in the start cycle is kept for the next word
                    trig_seen_ff <= trig & trig_rise;
                    peek_owed_ff <= 1'b0;
                end
                if (acc_busy_ff & flash_ack_i) begin
                    acc_busy_ff <= 1'b0;
                    flash_rd_o <= 1'b0;
                    {dath_ff, datl_ff} <= flash_data_i;
                    sadr_ff <= sadr_ff + {{(AW-1){1'b0}}, 1'b1};
                    if (sadr_ff >= scan_end_addr_i)
                        scan_go_ff <= 1'b0;
                end
            end else begin
                // Postponed request is served after exit
                if (pend_ff)
                    pend_ff <= 1'b1;
                if (acc_busy_ff & flash_ack_i) begin // RULE5 RULE10
                    acc_busy_ff <= 1'b0;
                    flash_rd_o <= 1'b0;
                    {dath_ff, datl_ff} <= flash_data_i;
                    sadr_ff <= sadr_ff + {{(AW-1){1'b0}}, 1'b1};
                    // Last word finished under halt must still end the scan
                    if (sadr_ff >= scan_end_addr_i)
                        scan_go_ff <= 1'b0;
                end
            end
            if (!halted & pend_ff & ~dbg_data_bp_i)
                pend_ff <= 1'b0; // RULE6
        end
    end

    // Read mux; unmapped reads zero
    always @* begin
        prdata_o = 32'h00000000;
        case (paddr_i)
            `CSD_ADDR_CTRL: prdata_o = {24'h000000, crc_en_ff, crc_go_ff, crc_busy,
                aug_ff, 2'b00, dir_ff, full_ff}; // RULE18
            `CSD_ADDR_LEN: prdata_o = {24'h000000, len_ff};
            `CSD_ADDR_DATH: prdata_o = {24'h000000, dath_ff};
            `CSD_ADDR_DATL: prdata_o = {24'h000000, datl_ff};
            `CSD_ADDR_SCTL: prdata_o = {24'h000000, scan_en_ff, scan_go_ff, acc_busy_ff,
                3'b000, mode_ff}; // RULE2
            `CSD_ADDR_SADR: prdata_o = {{(32-AW){1'b0}}, sadr_ff}; // RULE2
            `CSD_ADDR_SHIFT: prdata_o = {{(32-DW){1'b0}}, shift_ff};
            `CSD_ADDR_ACC: prdata_o = {{(32-DW){1'b0}}, acc_ff};
            default: prdata_o = 32'h00000000;
        endcase
    end
endmodule // csd_crc_scan

/* File: testbench/csd_crc_scan_properties.sv */
`timescale 1ns/100ps
module csd_crc_scan_properties #(parameter AW = 16) (
    // Clock, reset and bus
    input wire clock_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pslverr_o,
    input wire [31:0] prdata_o,
    // Debug and flash
    input wire dbg_halted_i,
    input wire dbg_entry_ok_o,
    input wire flash_rd_o,
    input wire [AW-1:0] flash_addr_o,
    input wire flash_ack_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire acc = psel_i && penable_i;
    reg go_ff;
    // Shadow of the CRC start bit
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) go_ff <= 1'b0;
        else if (acc && pwrite_i && paddr_i == 12'h000) go_ff <= pwdata_i[6];
    end
    property p_err_map; acc && paddr_i > 12'h01c |-> pslverr_o && (pwrite_i || prdata_o == 0); endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    property p_err_idle; !acc |-> !pslverr_o; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access phase");
    property p_ctrl_zero; acc && !pwrite_i && paddr_i == 12'h000 |-> prdata_o[3:2] == 2'b00; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("ctrl bits 3:2 set");
    property p_freeze_start; dbg_halted_i && !flash_rd_o |=> !flash_rd_o; endproperty
    a_freeze_start: assert property (p_freeze_start) else $error("fetch while halted");
    property p_freeze_addr; dbg_halted_i && !flash_rd_o ##1 dbg_halted_i |-> $stable(flash_addr_o); endproperty
    a_freeze_addr: assert property (p_freeze_addr) else $error("address moved while halted");
    property p_rd_hold; flash_rd_o && !flash_ack_i |=> flash_rd_o && $stable(flash_addr_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped before ack");
    property p_entry_wait; flash_rd_o |-> !dbg_entry_ok_o; endproperty
    a_entry_wait: assert property (p_entry_wait) else $error("debug entry during fetch");
    property p_crc_ready; $rose(flash_rd_o) |-> go_ff; endproperty
    a_crc_ready: assert property (p_crc_ready) else $error("fetch without CRC start");
    c_fetch: cover property (flash_rd_o && flash_ack_i);
    c_halt_rd: cover property (dbg_halted_i && flash_rd_o);
    c_err: cover property (pslverr_o);
endmodule // csd_crc_scan_properties

/* File: testbench/csd_flash_model.sv */
`timescale 1ns/100ps
module csd_flash_model #(parameter AW = 16, parameter DW = 16) (
    // Clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // Flash port
    input wire rd_i,
    input wire [AW-1:0] addr_i,
    input wire slow_i,
    output reg [DW-1:0] data_o,
    output reg ack_o
);
    reg [1:0] wait_ff;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_ff <= 2'h0;
            ack_o <= 1'b0;
            data_o <= {DW{1'b0}};
        end else if (rd_i && !ack_o && wait_ff == 2'h0) begin
            ack_o <= 1'b1;
            data_o <= DW'(addr_i) ^ DW'(16'h5a3c);
            wait_ff <= slow_i ? 2'h2 : 2'h0;
        end else begin
            // Released data toggles each cycle, showing the last word inverted every other cycle
            ack_o <= 1'b0;
            data_o <= ~data_o;
            if (rd_i && !ack_o) wait_ff <= wait_ff - 2'h1;
        end
    end
endmodule // csd_flash_model

/* File: testbench/csd_crc_scan_tb.sv */
`timescale 1ns/100ps
`include "csd_map.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module csd_crc_scan_tb;
    reg clock_i = 1'b0, rst_b_i = 1'b0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg [11:0] paddr_i = 0;
    reg [31:0] pwdata_i = 0, rd, rnd;
    wire pready_o, pslverr_o, dbg_entry_ok_o, cpu_stall_o, flash_rd_o, flash_ack_i;
    wire [31:0] prdata_o;
    wire [15:0] flash_addr_o, flash_data_i;
    reg dbg_halted_i = 0, dbg_ext_halt_i = 0, dbg_pc_bp_i = 0, dbg_data_bp_i = 0, dbg_step_i = 0;
    reg dbg_sw_bp_i = 0, cpu_go_instr_i = 0, cpu_dead_cycle_i = 0, cpu_instr_exec_i = 0;
    reg scan_trig_i = 0, slow = 0, halt_req = 0, er;
    reg [15:0] scan_end_addr_i = 0, sa;
    reg [7:0] b, c;
    reg [15:0] exp_q[$];
    integer error_cnt = 0, check_count = 0, seed = 32'hf956, m, k;
    csd_crc_scan DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .prdata_o(prdata_o), .dbg_halted_i(dbg_halted_i),
        .dbg_ext_halt_i(dbg_ext_halt_i), .dbg_pc_bp_i(dbg_pc_bp_i), .dbg_data_bp_i(dbg_data_bp_i),
        .dbg_step_i(dbg_step_i), .dbg_sw_bp_i(dbg_sw_bp_i), .dbg_entry_ok_o(dbg_entry_ok_o),
        .cpu_go_instr_i(cpu_go_instr_i), .cpu_dead_cycle_i(cpu_dead_cycle_i),
        .cpu_instr_exec_i(cpu_instr_exec_i), .cpu_stall_o(cpu_stall_o), .scan_trig_i(scan_trig_i),
        .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_data_i(flash_data_i),
        .flash_ack_i(flash_ack_i), .scan_end_addr_i(scan_end_addr_i));
    csd_flash_model u_flash (.clock_i(clock_i), .rst_b_i(rst_b_i), .rd_i(flash_rd_o),
        .addr_i(flash_addr_o), .slow_i(slow), .data_o(flash_data_i), .ack_o(flash_ack_i));
    initial forever #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        rnd = $random(seed);
        cpu_dead_cycle_i <= rnd[0];
        cpu_instr_exec_i <= rnd[1];
        scan_trig_i <= rnd[2];
        slow <= rnd[3];
        dbg_halted_i <= halt_req;
        dbg_ext_halt_i <= halt_req;
        dbg_pc_bp_i <= halt_req & rnd[4];
        dbg_data_bp_i <= halt_req & rnd[5];
        dbg_step_i <= halt_req & rnd[6];
        dbg_sw_bp_i <= halt_req & rnd[7];
        if (flash_rd_o === 1'b1 && flash_ack_i === 1'b1) begin
            `CHK("fetch addr", (exp_q.size() != 0) ? exp_q[0] : ~flash_addr_o, flash_addr_o)
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    task apb(input w, input [11:0] a, input [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task chk_rd(input [11:0] a, input [31:0] e, input [31:0] msk);
        apb(1'b0, a, 32'h0);
        `CHK("register read", e, rd & msk)
    endtask
    task summarize;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clock_i);
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        for (m = 0; m < 8; m++) chk_rd(12'(m * 4), {24'h0, `CSD_RST_BYTE}, 32'hffffffff);
        b = 8'($random(seed));
        apb(1'b1, `CSD_ADDR_LEN, {24'h0, b});
        chk_rd(`CSD_ADDR_LEN, {24'h0, b}, 32'hffffffff);
        apb(1'b1, `CSD_ADDR_DATH, {24'h0, ~b});
        chk_rd(`CSD_ADDR_DATH, {24'h0, ~b}, 32'hff);
        for (m = 0; m < 4; m++) begin
            c = {1'b1, 2'b00, m[0], 2'b00, m[1], 1'b0};
            apb(1'b1, `CSD_ADDR_CTRL, {24'h0, c});
            apb(1'b1, `CSD_ADDR_DATL, {24'h0, 8'($random(seed))});
            chk_rd(`CSD_ADDR_CTRL, {24'h0, c | 8'h01}, 32'hffffffdf);
            apb(1'b1, `CSD_ADDR_CTRL, {24'h0, c | 8'h40});
            k = 0;
            do begin apb(1'b0, `CSD_ADDR_CTRL, 0); k++; end while (rd[5] !== 1'b0 && k < 100);
            `CHK("ctrl after shift", {24'h0, c | 8'h40}, rd)
        end
        apb(1'b1, 12'h040, 32'hffffffff);
        `CHK("unmapped error", 1'b1, er)
        chk_rd(`CSD_ADDR_LEN, {24'h0, b}, 32'hffffffff);
        apb(1'b1, `CSD_ADDR_CTRL, 32'hc0);
        for (m = 0; m < 4; m++) begin
            sa = 16'($random(seed)) & 16'h7ff0;
            scan_end_addr_i <= sa + 16'h3;
            for (k = 0; k < 4; k++) exp_q.push_back(sa + k[15:0]);
            apb(1'b1, `CSD_ADDR_SADR, {16'h0, sa});
            apb(1'b1, `CSD_ADDR_SCTL, 32'h80 | m);
            cpu_go_instr_i <= 1'b1;
            apb(1'b1, `CSD_ADDR_SCTL, 32'hc0 | m);
            cpu_go_instr_i <= 1'b0;
            halt_req <= 1'b1;
            repeat (2) @(posedge clock_i);
            chk_rd(`CSD_ADDR_SCTL, 32'hc0 | m, 32'hc3);
            repeat (12) @(posedge clock_i);
            halt_req <= 1'b0;
            k = 0;
            do begin apb(1'b0, `CSD_ADDR_SCTL, 0); k++; end while (rd[6] !== 1'b0 && k < 300);
            `CHK("fetches left", 0, exp_q.size())
            `CHK("stall after scan", 1'b0, cpu_stall_o)
            chk_rd(`CSD_ADDR_SADR, {16'h0, sa + 16'h4}, 32'hffff);
            apb(1'b1, `CSD_ADDR_SCTL, 32'h0);
        end
        summarize;
    end
endmodule // csd_crc_scan_tb
bind csd_crc_scan csd_crc_scan_properties #(.AW(AW)) u_prop (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .dbg_halted_i(dbg_halted_i),
    .dbg_entry_ok_o(dbg_entry_ok_o), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
    .flash_ack_i(flash_ack_i));
